// ==== gct_counter_timer.sv ====
// General-purpose 32-bit counter/timer channel with APB register access
//
// Notes on behaviour
// - Internal source runs from the base clock
// - Operation starts on command, on the gate edge or on the start edge
// - Divider at least two divides base clock
// - No gating enables at once on command
// - Low-level gating counts while gate low
// - High-level gating counts while gate high
// - Falling-edge gating starts on gate fall
// - Rising-edge gating starts on gate rise
// - Pulse polarity selects the active level of the first duty share
// - Active part equals programmed duty percentage
// - Active polarities are software configurable
// - Event mode counts clock rises or divider ticks while gated
// - Event count wraps to zero and continues
// - Up/down direction follows gate level
// - Up/down ignores gating, uses external clock
// - Start and stop each pick one edge
// - Measure counts start to stop, then holds
// - Measure counts base clock cycles
// - Count captured at each sample strobe while in_list is high
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module gct_counter_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gct_pkg::gct_pins_t pins,
  input wire logic sample_strobe,
  input wire logic in_list,
  output gct_pkg::gct_sample_t sample,
  output logic pulse_out
);

  typedef struct packed {
    logic [2:0] gsync;
    logic [2:0] csync;
    gct_pkg::gct_fsm_t fsm;
    gct_pkg::gct_ctrl_t ctrl;
    logic [31:0] div;
    logic [6:0] duty;
    logic [31:0] cnt;
    logic [31:0] phase;
    logic wrapped;
    logic mdone;
    gct_pkg::gct_sample_t smp;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pulse;
  } gct_state_t;

  gct_state_t s_q;
  gct_state_t s_d;

  logic g;
  logic g_rise;
  logic g_fall;
  logic c_rise;
  logic c_fall;
  logic [31:0] div_eff;
  logic [38:0] prod;
  logic [31:0] thresh;
  logic step;
  logic wrap;
  logic gate_ok;
  logic start_hit;
  logic stop_hit;
  logic active_lvl;
  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] rd;
  logic [31:0] status;
  logic [6:0] duty_w;
  logic wrap_set;
  logic mdone_set;

  // Shared zero word for clears and unused read data
  localparam logic [31:0] GCT_ZERO = 32'h0000_0000;

  // Edge selection for the measurement start and stop events
  function automatic logic edge_hit(
    input gct_pkg::gct_edge_t sel,
    input logic gr,
    input logic gf,
    input logic cr,
    input logic cf
  );
    logic hit;
    hit = 1'b0;
    unique case (sel)
      gct_pkg::GCT_EDGE_GATE_RISE: hit = gr;
      gct_pkg::GCT_EDGE_GATE_FALL: hit = gf;
      gct_pkg::GCT_EDGE_CLK_RISE: hit = cr;
      gct_pkg::GCT_EDGE_CLK_FALL: hit = cf;
    endcase
    return hit;
  endfunction : edge_hit

  // Whole next state of the channel in one process
  always_comb begin
    s_d = s_q;
    // Hardware set events, so that a clear in the same cycle loses
    wrap_set = 1'b0;
    mdone_set = 1'b0;

    // Two-stage synchronisers, third stage only for edge detection
    s_d.gsync = {s_q.gsync[1:0], pins.gate_in};
    s_d.csync = {s_q.csync[1:0], pins.clk_in};
    g = s_q.gsync[1];
    g_rise = s_q.gsync[1] & ~s_q.gsync[2];
    g_fall = ~s_q.gsync[1] & s_q.gsync[2];
    c_rise = s_q.csync[1] & ~s_q.csync[2];
    c_fall = ~s_q.csync[1] & s_q.csync[2];

    // Timing chain: one step per base cycle or per external rising edge
    // A divider below two would leave no room for both an active and an inactive part
    div_eff = (s_q.div < gct_pkg::GCT_DIV_MIN) ? gct_pkg::GCT_DIV_MIN : s_q.div;
    step = s_q.ctrl.ext_src ? c_rise : 1'b1;
    wrap = step && (s_q.phase >= div_eff - 32'h0000_0001);
    // Product is 39 bits wide so divider times duty never overflows
    prod = {7'h00, div_eff} * {32'h0000_0000, s_q.duty};
    thresh = 32'(prod / gct_pkg::GCT_DUTY_FULL);

    unique case (s_q.ctrl.gate)
      gct_pkg::GCT_GATE_NONE: gate_ok = 1'b1;
      gct_pkg::GCT_GATE_LOW: gate_ok = ~g;
      gct_pkg::GCT_GATE_HIGH: gate_ok = g;
      // Edge gating has already been met once the sequence runs
      gct_pkg::GCT_GATE_FALL: gate_ok = 1'b1;
      gct_pkg::GCT_GATE_RISE: gate_ok = 1'b1;
      default: gate_ok = 1'b0;
    endcase

    start_hit = edge_hit(s_q.ctrl.start_edge, g_rise, g_fall, c_rise, c_fall);
    stop_hit = edge_hit(s_q.ctrl.stop_edge, g_rise, g_fall, c_rise, c_fall);
    active_lvl = s_q.ctrl.pulse_pol;

    // Operating sequence
    unique case (s_q.fsm)
      gct_pkg::GCT_FSM_IDLE: begin
        s_d.phase = 32'h0000_0000;
      end
      gct_pkg::GCT_FSM_WAIT: begin
        // Edges seen before the start command are not remembered
        if (s_q.ctrl.mode == gct_pkg::GCT_MODE_MEASURE) begin
          if (start_hit) begin
            s_d.fsm = gct_pkg::GCT_FSM_RUN;
            s_d.cnt = GCT_ZERO;
          end
        end else if (s_q.ctrl.gate == gct_pkg::GCT_GATE_FALL) begin
          if (g_fall) begin
            s_d.fsm = gct_pkg::GCT_FSM_RUN;
          end
        end else if (g_rise) begin
          s_d.fsm = gct_pkg::GCT_FSM_RUN;
        end
      end
      gct_pkg::GCT_FSM_RUN: begin
        if (step) begin
          s_d.phase = wrap ? 32'h0000_0000 : s_q.phase + 32'h0000_0001;
        end
        unique case (s_q.ctrl.mode)
          gct_pkg::GCT_MODE_EVENT: begin
            // Internal source counts divider ticks, external counts clock rises
            if (gate_ok && (s_q.ctrl.ext_src ? c_rise : wrap)) begin
              s_d.cnt = s_q.cnt + 32'h0000_0001;
              if (s_q.cnt == 32'hffff_ffff) begin
                s_d.wrapped = 1'b1;
                wrap_set = 1'b1;
              end
            end
          end
          gct_pkg::GCT_MODE_UPDOWN: begin
            // Gate level is the direction; the gate type is ignored
            if (c_rise) begin
              s_d.cnt = g ? s_q.cnt + 32'h0000_0001 : s_q.cnt - 32'h0000_0001;
            end
          end
          gct_pkg::GCT_MODE_MEASURE: begin
            // The cycle of the stop edge itself is not counted
            if (stop_hit) begin
              s_d.fsm = gct_pkg::GCT_FSM_DONE;
              s_d.mdone = 1'b1;
              mdone_set = 1'b1;
            end else begin
              s_d.cnt = s_q.cnt + 32'h0000_0001;
            end
          end
          gct_pkg::GCT_MODE_PULSE: begin
          end
        endcase
      end
      gct_pkg::GCT_FSM_DONE: begin
        // Count holds until the next start command
        s_d.phase = 32'h0000_0000;
      end
      default: begin
        s_d.fsm = gct_pkg::GCT_FSM_IDLE;
      end
    endcase

    // Pulse output: active for the first duty share of each period
    if (s_q.fsm == gct_pkg::GCT_FSM_RUN && s_q.ctrl.mode == gct_pkg::GCT_MODE_PULSE && gate_ok) begin
      s_d.pulse = (s_q.phase < thresh) ? active_lvl : ~active_lvl;
    end else begin
      s_d.pulse = ~active_lvl;
    end

    // Acquisition stream capture
    // Data holds the last capture between strobes
    s_d.smp.valid = 1'b0;
    if (sample_strobe && in_list) begin
      s_d.smp.valid = 1'b1;
      s_d.smp.data = s_q.cnt;
    end

    // APB slave, one wait state on every transfer
    // Writes land at the edge where pready is sampled high
    acc = psel && penable;
    wr = acc && s_q.pready && pwrite;
    mapped = (paddr == gct_pkg::GCT_OFF_CTRL) || (paddr == gct_pkg::GCT_OFF_DIV) ||
             (paddr == gct_pkg::GCT_OFF_DUTY) || (paddr == gct_pkg::GCT_OFF_COUNT) ||
             (paddr == gct_pkg::GCT_OFF_SAMPLE) || (paddr == gct_pkg::GCT_OFF_STATUS);

    // Live state bits plus the two sticky flags
    status = GCT_ZERO;
    status[gct_pkg::GCT_ST_IDLE] = s_q.fsm[0];
    status[gct_pkg::GCT_ST_WAIT] = s_q.fsm[1];
    status[gct_pkg::GCT_ST_RUN] = s_q.fsm[2];
    status[gct_pkg::GCT_ST_DONE] = s_q.fsm[3];
    status[gct_pkg::GCT_ST_GATE] = g;
    status[gct_pkg::GCT_ST_CLK] = s_q.csync[1];
    status[gct_pkg::GCT_ST_PULSE] = s_q.pulse;
    status[gct_pkg::GCT_ST_WRAP] = s_q.wrapped;
    status[gct_pkg::GCT_ST_MDONE] = s_q.mdone;

    // Read data is registered in the cycle before pready
    unique case (paddr)
      gct_pkg::GCT_OFF_CTRL: rd = {20'h0_0000, s_q.ctrl};
      gct_pkg::GCT_OFF_DIV: rd = s_q.div;
      gct_pkg::GCT_OFF_DUTY: rd = {25'h000_0000, s_q.duty};
      gct_pkg::GCT_OFF_COUNT: rd = s_q.cnt;
      gct_pkg::GCT_OFF_SAMPLE: rd = s_q.smp.data;
      gct_pkg::GCT_OFF_STATUS: rd = status;
      default: rd = GCT_ZERO;
    endcase

    // pready rises one cycle after the access phase opens
    s_d.pready = acc && !s_q.pready;
    if (acc && !s_q.pready) begin
      s_d.prdata = pwrite ? GCT_ZERO : rd;
      s_d.pslverr = !mapped;
    end else begin
      s_d.pslverr = 1'b0;
    end

    // Duty in pwdata[6:0] above full scale is clamped to full scale
    duty_w = (pwdata[6:0] > gct_pkg::GCT_DUTY_MAX) ? gct_pkg::GCT_DUTY_MAX : pwdata[6:0];

    if (wr) begin
      unique case (paddr)
        gct_pkg::GCT_OFF_CTRL: begin
          // Enable high is the start command; any write restarts the period
          s_d.ctrl = pwdata[gct_pkg::GCT_CTRL_W-1:0];
          s_d.phase = 32'h0000_0000;
          if (!pwdata[0]) begin
            s_d.fsm = gct_pkg::GCT_FSM_IDLE;
          end else if (pwdata[2:1] == gct_pkg::GCT_MODE_MEASURE) begin
            s_d.fsm = gct_pkg::GCT_FSM_WAIT;
            s_d.cnt = GCT_ZERO;
          end else if (pwdata[2:1] != gct_pkg::GCT_MODE_UPDOWN &&
                       (pwdata[5:3] == gct_pkg::GCT_GATE_FALL || pwdata[5:3] == gct_pkg::GCT_GATE_RISE)) begin
            s_d.fsm = gct_pkg::GCT_FSM_WAIT;
          end else begin
            s_d.fsm = gct_pkg::GCT_FSM_RUN;
          end
        end
        gct_pkg::GCT_OFF_DIV: s_d.div = pwdata;
        gct_pkg::GCT_OFF_DUTY: s_d.duty = duty_w;
        gct_pkg::GCT_OFF_COUNT: s_d.cnt = pwdata;
        gct_pkg::GCT_OFF_STATUS: begin
          // Write one to clear; a hardware set in the same cycle wins
          if (pwdata[gct_pkg::GCT_ST_WRAP] && !wrap_set) begin
            s_d.wrapped = 1'b0;
          end
          if (pwdata[gct_pkg::GCT_ST_MDONE] && !mdone_set) begin
            s_d.mdone = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q.gsync <= 3'h0;
      s_q.csync <= 3'h0;
      s_q.fsm <= gct_pkg::GCT_FSM_IDLE;
      s_q.ctrl <= gct_pkg::GCT_CTRL_RESET;
      s_q.div <= gct_pkg::GCT_DIV_RESET;
      s_q.duty <= gct_pkg::GCT_DUTY_RESET;
      s_q.cnt <= gct_pkg::GCT_COUNT_RESET;
      s_q.phase <= 32'h0000_0000;
      s_q.wrapped <= 1'b0;
      s_q.mdone <= 1'b0;
      s_q.smp <= '0;
      s_q.prdata <= 32'h0000_0000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      // Pulse rests at the inactive level of the reset polarity
      s_q.pulse <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign sample = s_q.smp;
  assign pulse_out = s_q.pulse;

endmodule : gct_counter_timer

`default_nettype wire

// ==== gct_pkg.sv ====
// Shared constants, encodings and carrier types of the general counter/timer
package gct_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] GCT_OFF_CTRL = 8'h00;
  localparam logic [7:0] GCT_OFF_DIV = 8'h04;
  localparam logic [7:0] GCT_OFF_DUTY = 8'h08;
  localparam logic [7:0] GCT_OFF_COUNT = 8'h0c;
  localparam logic [7:0] GCT_OFF_SAMPLE = 8'h10;
  localparam logic [7:0] GCT_OFF_STATUS = 8'h14;

  // Reset values
  localparam logic [31:0] GCT_DIV_RESET = 32'h0000_0002;
  localparam logic [6:0] GCT_DUTY_RESET = 7'h32;
  localparam logic [31:0] GCT_COUNT_RESET = 32'h0000_0000;

  // Smallest divider the timing chain accepts
  localparam logic [31:0] GCT_DIV_MIN = 32'h0000_0002;
  // Duty cycle is a percentage of this full scale
  localparam logic [38:0] GCT_DUTY_FULL = 39'h00_0000_0064;
  localparam logic [6:0] GCT_DUTY_MAX = 7'h64;

  // Base time frequency, in Hz; the module clock stands for this base
  localparam int GCT_BASE_HZ = 48_000_000;

  // Status register bit positions
  localparam int GCT_ST_IDLE = 0;
  localparam int GCT_ST_WAIT = 1;
  localparam int GCT_ST_RUN = 2;
  localparam int GCT_ST_DONE = 3;
  localparam int GCT_ST_GATE = 4;
  localparam int GCT_ST_CLK = 5;
  localparam int GCT_ST_PULSE = 6;
  localparam int GCT_ST_WRAP = 8;
  localparam int GCT_ST_MDONE = 9;

  // Control register width and field layout (see gct_ctrl_t)
  localparam int GCT_CTRL_W = 12;

  typedef enum logic [1:0] {
    GCT_MODE_EVENT = 2'h0,
    GCT_MODE_UPDOWN = 2'h1,
    GCT_MODE_MEASURE = 2'h2,
    GCT_MODE_PULSE = 2'h3
  } gct_mode_t;

  typedef enum logic [2:0] {
    GCT_GATE_NONE = 3'h0,
    GCT_GATE_LOW = 3'h1,
    GCT_GATE_HIGH = 3'h2,
    GCT_GATE_FALL = 3'h3,
    GCT_GATE_RISE = 3'h4
  } gct_gate_t;

  typedef enum logic [1:0] {
    GCT_EDGE_GATE_RISE = 2'h0,
    GCT_EDGE_GATE_FALL = 2'h1,
    GCT_EDGE_CLK_RISE = 2'h2,
    GCT_EDGE_CLK_FALL = 2'h3
  } gct_edge_t;

  typedef enum logic [3:0] {
    GCT_FSM_IDLE = 4'h1,
    GCT_FSM_WAIT = 4'h2,
    GCT_FSM_RUN = 4'h4,
    GCT_FSM_DONE = 4'h8
  } gct_fsm_t;

  // Bit 0 enable, [2:1] mode, [5:3] gate, 6 external clock, [8:7] start, [10:9] stop, 11 pulse polarity
  typedef struct packed {
    logic pulse_pol;
    gct_edge_t stop_edge;
    gct_edge_t start_edge;
    logic ext_src;
    gct_gate_t gate;
    gct_mode_t mode;
    logic enable;
  } gct_ctrl_t;

  localparam gct_ctrl_t GCT_CTRL_RESET = '{
    pulse_pol: 1'b0,
    stop_edge: GCT_EDGE_GATE_FALL,
    start_edge: GCT_EDGE_GATE_RISE,
    ext_src: 1'b1,
    gate: GCT_GATE_NONE,
    mode: GCT_MODE_EVENT,
    enable: 1'b0
  };

  // External pins
  typedef struct packed {
    logic clk_in;
    logic gate_in;
  } gct_pins_t;

  // Acquisition stream capture port
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } gct_sample_t;

endpackage : gct_pkg

// ==== gct_properties.sv ====
// Concurrent checks on the counter/timer bus and sample ports
`timescale 1ns/10ps
`default_nettype none
module gct_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire gct_pkg::gct_pins_t pins,
  input wire logic sample_strobe,
  input wire logic in_list,
  input wire gct_pkg::gct_sample_t sample,
  input wire logic pulse_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_capture;
    sample_strobe && in_list;
  endsequence
  bus_answer_a: assert property (s_access |=> pready) else $error("no answer after access");
  bus_single_a: assert property (pready |=> !pready) else $error("pready held too long");
  bus_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  bus_err_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  bus_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
  capture_valid_a: assert property (s_capture |=> sample.valid) else $error("capture missing");
  capture_cause_a: assert property (sample.valid |-> $past(sample_strobe && in_list)) else $error("stray capture");
  capture_hold_a: assert property (!(sample_strobe && in_list) |=> $stable(sample.data)) else $error("data moved");
  cover property (s_capture);
endmodule : gct_properties
bind gct_counter_timer gct_properties u_props (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins(pins), .sample_strobe(sample_strobe), .in_list(in_list), .sample(sample), .pulse_out(pulse_out));
`default_nettype wire

// ==== gct_pin_model.sv ====
// External clock and gate source wired to the counter pins
`timescale 1ns/10ps
`default_nettype none
module gct_pin_model (
  input wire logic clock,
  output var gct_pkg::gct_pins_t pins
);
  initial pins = '0;
  task drive(input logic is_clk, input logic v);
    @(posedge clock);
    if (is_clk) pins.clk_in <= v;
    else pins.gate_in <= v;
  endtask : drive
  // Three cycles high, three low: far inside the allowed rate; still between bursts
  task pulses(input int n);
    repeat (n) begin
      drive(1'b1, 1'b1);
      repeat (2) @(posedge clock);
      drive(1'b1, 1'b0);
      repeat (2) @(posedge clock);
    end
  endtask : pulses
endmodule : gct_pin_model
`default_nettype wire

// ==== tb_general_counter_timer.sv ====
// Self-checking bench for the counter/timer channel
`timescale 1ns/10ps
`default_nettype none
module tb_general_counter_timer;
  typedef struct packed {
    gct_pkg::gct_mode_t m;
    gct_pkg::gct_gate_t g;
    logic gl;
    logic [31:0] pre;
    logic [31:0] exp;
  } gct_row_t;
  localparam gct_pkg::gct_edge_t GR = gct_pkg::GCT_EDGE_GATE_RISE;
  localparam gct_pkg::gct_edge_t GF = gct_pkg::GCT_EDGE_GATE_FALL;
  localparam gct_pkg::gct_mode_t EV = gct_pkg::GCT_MODE_EVENT;
  localparam gct_pkg::gct_mode_t UD = gct_pkg::GCT_MODE_UPDOWN;
  localparam gct_pkg::gct_mode_t MS = gct_pkg::GCT_MODE_MEASURE;
  localparam gct_pkg::gct_gate_t NO = gct_pkg::GCT_GATE_NONE;
  localparam gct_pkg::gct_gate_t LO = gct_pkg::GCT_GATE_LOW;
  localparam gct_pkg::gct_gate_t HI = gct_pkg::GCT_GATE_HIGH;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sample_strobe = 1'b0;
  logic in_list = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] ref_cnt;
  logic pready;
  logic pslverr;
  logic pulse_out;
  logic err;
  gct_pkg::gct_pins_t pins;
  gct_pkg::gct_sample_t sample;
  int n_mismatch = 0;
  int compares = 0;
  int k;
  int n;
  gct_row_t rows [8];
  always #20 clock = ~clock;
  gct_counter_timer DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .sample_strobe(sample_strobe), .in_list(in_list), .sample(sample), .pulse_out(pulse_out));
  gct_pin_model u_pins (.clock(clock), .pins(pins));
  task conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 10; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 10) begin
      n_mismatch++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] cfg(gct_pkg::gct_mode_t m, gct_pkg::gct_gate_t g, logic ext,
    gct_pkg::gct_edge_t s, gct_pkg::gct_edge_t p, logic pol);
    gct_pkg::gct_ctrl_t c;
    c = '{pol, p, s, ext, g, m, 1'b1};
    return {20'h0, c};
  endfunction : cfg
  // Start edge on entry to level lvl, stop edge on leaving it
  task meas(gct_pkg::gct_edge_t s, gct_pkg::gct_edge_t p, logic clk, logic lvl, int w);
    u_pins.drive(clk, ~lvl);
    repeat (5) @(posedge clock);
    apb(1'b1, gct_pkg::GCT_OFF_CTRL, cfg(MS, NO, 1'b0, s, p, 1'b0));
    repeat (5) @(posedge clock);
    u_pins.drive(clk, lvl);
    repeat (w) @(posedge clock);
    u_pins.drive(clk, ~lvl);
    repeat (6) @(posedge clock);
    apb(1'b0, gct_pkg::GCT_OFF_COUNT, 32'h0);
  endtask : meas
  initial begin
    rows = '{'{EV, NO, 1'b1, 32'h0, 32'h3}, '{EV, LO, 1'b0, 32'h0, 32'h3}, '{EV, LO, 1'b1, 32'h0, 32'h0},
      '{EV, HI, 1'b1, 32'h0, 32'h3}, '{EV, HI, 1'b0, 32'h0, 32'h0}, '{UD, LO, 1'b1, 32'ha, 32'hd},
      '{UD, HI, 1'b0, 32'ha, 32'h7}, '{EV, NO, 1'b0, 32'hffffffff, 32'h2}};
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, gct_pkg::GCT_OFF_CTRL, 32'h0);
    chk(rd, {20'h0, gct_pkg::GCT_CTRL_RESET}, "ctrl reset");
    apb(1'b0, gct_pkg::GCT_OFF_DIV, 32'h0);
    chk(rd, gct_pkg::GCT_DIV_RESET, "div reset");
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
    $display("test reset values done");
    for (k = 0; k < 8; k++) begin
      u_pins.drive(1'b0, rows[k].gl);
      apb(1'b1, gct_pkg::GCT_OFF_CTRL, cfg(rows[k].m, rows[k].g, 1'b1, GR, GF, 1'b0));
      apb(1'b1, gct_pkg::GCT_OFF_COUNT, rows[k].pre);
      u_pins.pulses(3);
      repeat (6) @(posedge clock);
      apb(1'b0, gct_pkg::GCT_OFF_COUNT, 32'h0);
      chk(rd, rows[k].exp, "row count");
    end
    apb(1'b0, gct_pkg::GCT_OFF_STATUS, 32'h0);
    chk(32'(rd[gct_pkg::GCT_ST_WRAP]), 32'h1, "wrap flag");
    apb(1'b1, gct_pkg::GCT_OFF_STATUS, 32'h1 << gct_pkg::GCT_ST_WRAP);
    apb(1'b0, gct_pkg::GCT_OFF_STATUS, 32'h0);
    chk(32'(rd[gct_pkg::GCT_ST_WRAP]), 32'h0, "wrap cleared");
    sample_strobe <= 1'b1;
    in_list <= 1'b1;
    @(posedge clock);
    sample_strobe <= 1'b0;
    @(posedge clock);
    chk({sample.valid, sample.data[30:0]}, 32'h80000002, "capture");
    sample_strobe <= 1'b1;
    in_list <= 1'b0;
    @(posedge clock);
    sample_strobe <= 1'b0;
    @(posedge clock);
    chk({31'h0, sample.valid}, 32'h0, "capture refused");
    $display("test table done");
    for (k = 0; k < 2; k++) begin
      u_pins.drive(1'b0, k[0]);
      repeat (5) @(posedge clock);
      apb(1'b1, gct_pkg::GCT_OFF_CTRL, cfg(EV, k ? gct_pkg::GCT_GATE_FALL : gct_pkg::GCT_GATE_RISE, 1'b1, GR, GF, 1'b0));
      apb(1'b1, gct_pkg::GCT_OFF_COUNT, 32'h0);
      u_pins.pulses(2);
      u_pins.drive(1'b0, ~k[0]);
      repeat (5) @(posedge clock);
      u_pins.pulses(2);
      repeat (6) @(posedge clock);
      apb(1'b0, gct_pkg::GCT_OFF_COUNT, 32'h0);
      chk(rd, 32'h2, "edge gate");
    end
    meas(GR, GF, 1'b0, 1'b1, 10);
    ref_cnt = rd;
    meas(GR, GF, 1'b0, 1'b1, 20);
    chk(rd - ref_cnt, 32'ha, "interval");
    ref_cnt = rd;
    u_pins.drive(1'b0, 1'b1);
    repeat (5) @(posedge clock);
    u_pins.drive(1'b0, 1'b0);
    repeat (6) @(posedge clock);
    apb(1'b0, gct_pkg::GCT_OFF_COUNT, 32'h0);
    chk(rd, ref_cnt, "hold");
    meas(GF, GR, 1'b0, 1'b0, 20);
    chk(rd, ref_cnt, "gate fall start");
    meas(gct_pkg::GCT_EDGE_CLK_RISE, gct_pkg::GCT_EDGE_CLK_FALL, 1'b1, 1'b1, 20);
    chk(rd, ref_cnt, "clock rise start");
    meas(gct_pkg::GCT_EDGE_CLK_FALL, gct_pkg::GCT_EDGE_CLK_RISE, 1'b1, 1'b0, 20);
    chk(rd, ref_cnt, "clock fall start");
    $display("test measure done");
    apb(1'b1, gct_pkg::GCT_OFF_DIV, 32'ha);
    apb(1'b1, gct_pkg::GCT_OFF_DUTY, 32'h1e);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, gct_pkg::GCT_OFF_CTRL, cfg(gct_pkg::GCT_MODE_PULSE, NO, 1'b0, GR, GF, k[0]));
      repeat (30) @(posedge clock);
      n = 0;
      repeat (100) begin
        @(posedge clock);
        if (pulse_out === k[0]) n++;
      end
      chk(32'(n), 32'h1e, "active share");
    end
    apb(1'b1, gct_pkg::GCT_OFF_CTRL, cfg(EV, NO, 1'b0, GR, GF, 1'b0));
    apb(1'b1, gct_pkg::GCT_OFF_COUNT, 32'h0);
    repeat (95) @(posedge clock);
    apb(1'b0, gct_pkg::GCT_OFF_COUNT, 32'h0);
    chk(rd, 32'ha, "internal ticks");
    rst_n <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    chk({31'h0, pulse_out}, 32'h1, "idle level");
    rst_n <= 1'b1;
    apb(1'b0, gct_pkg::GCT_OFF_DIV, 32'h0);
    chk(rd, gct_pkg::GCT_DIV_RESET, "div after reset");
    $display("test pulse and reset done");
    conclude();
  end
endmodule : tb_general_counter_timer
`default_nettype wire
